// ===== design/ltc_flag.v
// Purpose: one diagnostic limit flag, latched or transparent
// Assumes: check_i pulses once per completed comparison
// Notes: set beats the clear from a diagnostic read in the same cycle
`timescale 1ns/1ps
module ltc_flag (
	input  wire clock_i,
	input  wire rst_n_i,
	input  wire check_i,
	input  wire fault_i,
	input  wire latch_i,
	input  wire diag_read_i,
	output reg  flag_o
);
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			flag_o <= 1'b0;
		end else if (check_i && fault_i) begin
			flag_o <= 1'b1;
		end else if (latch_i) begin
			if (diag_read_i) begin
				flag_o <= 1'b0;
			end
		end else if (check_i) begin
			flag_o <= 1'b0;
		end
	end
endmodule // ltc_flag

// ===== design/ltc_limit_threshold_comparator.v
// Purpose: alert limit registers and threshold comparison of a power monitor
// Assumes: register port comes from the serial interface on the same clock; results arrive
//          from the measurement engine on the same clock, each with a one-cycle valid pulse
// Notes: flags go out as level outputs; the full diagnostic register lives elsewhere
`timescale 1ns/1ps
`include "ltc_map.vh"
module ltc_limit_threshold_comparator (
	input  wire        clock_i,
	input  wire        rst_n_i,
	input  wire [7:0]  reg_addr_i,
	input  wire        reg_wr_i,
	input  wire [15:0] reg_wdata_i,
	input  wire        reg_rd_i,
	output reg  [15:0] reg_rdata_o,
	output reg         reg_hit_o,
	input  wire        alert_latch_enable_i,
	input  wire        alert_on_average_i,
	input  wire        diag_read_i,
	input  wire [15:0] shunt_raw_i,
	input  wire        shunt_raw_valid_i,
	input  wire [15:0] shunt_avg_i,
	input  wire        shunt_avg_valid_i,
	input  wire [15:0] bus_raw_i,
	input  wire        bus_raw_valid_i,
	input  wire [15:0] bus_avg_i,
	input  wire        bus_avg_valid_i,
	input  wire [11:0] temp_raw_i,
	input  wire        temp_raw_valid_i,
	input  wire [11:0] temp_avg_i,
	input  wire        temp_avg_valid_i,
	input  wire [23:0] power_i,
	input  wire        power_valid_i,
	output wire        shunt_over_flag_o,
	output wire        shunt_under_flag_o,
	output wire        bus_over_flag_o,
	output wire        bus_under_flag_o,
	output wire        temp_over_flag_o,
	output wire        power_over_flag_o
);
	reg  [15:0] shunt_over_threshold;
	reg  [15:0] shunt_under_threshold;
	reg  [14:0] bus_over_threshold;
	reg  [14:0] bus_under_threshold;
	reg  [11:0] temp_threshold_field;
	reg  [15:0] power_over_field;
	reg  [15:0] next_rdata;
	reg         next_hit;
	reg         sel_shunt_over;
	reg         sel_shunt_under;
	reg         sel_bus_over;
	reg         sel_bus_under;
	reg         sel_temp_over;
	reg         sel_power_over;
	reg         sel_maker_id;
	wire [15:0] shunt_sel;
	wire [15:0] bus_sel;
	wire [11:0] temp_sel;
	wire        shunt_chk;
	wire        bus_chk;
	wire        temp_chk;
	wire [15:0] power_top;
	wire [`LTC_NFLAGS-1:0] chk;
	wire [`LTC_NFLAGS-1:0] fault;
	wire [`LTC_NFLAGS-1:0] flags;

	// one address decode feeds both the write and the read path, so they cannot disagree
	// unmapped addresses leave every select low
	always @* begin
		sel_shunt_over  = 1'b0;
		sel_shunt_under = 1'b0;
		sel_bus_over    = 1'b0;
		sel_bus_under   = 1'b0;
		sel_temp_over   = 1'b0;
		sel_power_over  = 1'b0;
		sel_maker_id    = 1'b0;
		if (reg_addr_i == `LTC_ADDR_SHUNT_OVER) begin
			sel_shunt_over = 1'b1;
		end else if (reg_addr_i == `LTC_ADDR_SHUNT_UNDER) begin
			sel_shunt_under = 1'b1;
		end else if (reg_addr_i == `LTC_ADDR_BUS_OVER) begin
			sel_bus_over = 1'b1;
		end else if (reg_addr_i == `LTC_ADDR_BUS_UNDER) begin
			sel_bus_under = 1'b1;
		end else if (reg_addr_i == `LTC_ADDR_TEMP_OVER) begin
			sel_temp_over = 1'b1;
		end else if (reg_addr_i == `LTC_ADDR_POWER_OVER) begin
			sel_power_over = 1'b1;
		end else if (reg_addr_i == `LTC_ADDR_MAKER_ID) begin
			sel_maker_id = 1'b1;
		end
	end

	// register writes; a write lands before the next result pulse is compared
	// one process per threshold keeps each reset value next to its own storage
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			shunt_over_threshold <= `LTC_RST_SHUNT_OVER;
		end else if (reg_wr_i && sel_shunt_over) begin
			shunt_over_threshold <= reg_wdata_i;
		end
	end

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			shunt_under_threshold <= `LTC_RST_SHUNT_UNDER;
		end else if (reg_wr_i && sel_shunt_under) begin
			shunt_under_threshold <= reg_wdata_i;
		end
	end

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			bus_over_threshold <= `LTC_RST_BUS_OVER;
		end else if (reg_wr_i && sel_bus_over) begin
			bus_over_threshold <= reg_wdata_i[14:0];
		end
	end

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			bus_under_threshold <= `LTC_RST_BUS_UNDER;
		end else if (reg_wr_i && sel_bus_under) begin
			bus_under_threshold <= reg_wdata_i[14:0];
		end
	end

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			temp_threshold_field <= `LTC_RST_TEMP_OVER;
		end else if (reg_wr_i && sel_temp_over) begin
			temp_threshold_field <= reg_wdata_i[15:`LTC_TEMP_LSB];
		end
	end

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			power_over_field <= `LTC_RST_POWER_OVER;
		end else if (reg_wr_i && sel_power_over) begin
			power_over_field <= reg_wdata_i;
		end
	end
	// the identification word has no storage, so a write to it is dropped

	// read decode; unmapped addresses return zero with reg_hit_o low
	always @* begin
		next_rdata = 16'h0000;
		next_hit   = 1'b1;
		if (sel_shunt_over) begin
			next_rdata = shunt_over_threshold;
		end else if (sel_shunt_under) begin
			next_rdata = shunt_under_threshold;
		end else if (sel_bus_over) begin
			next_rdata = {1'b0, bus_over_threshold};
		end else if (sel_bus_under) begin
			next_rdata = {1'b0, bus_under_threshold};
		end else if (sel_temp_over) begin
			next_rdata = {temp_threshold_field, 4'h0};
		end else if (sel_power_over) begin
			next_rdata = power_over_field;
		end else if (sel_maker_id) begin
			next_rdata = `LTC_MAKER_CODE;
		end else begin
			next_hit = 1'b0;
		end
	end

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 16'h0000;
			reg_hit_o   <= 1'b0;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
			reg_hit_o   <= next_hit;
		end
	end

	// result source: averaged or raw, each with its own completion pulse
	assign shunt_sel = alert_on_average_i ? shunt_avg_i : shunt_raw_i;
	assign shunt_chk = alert_on_average_i ? shunt_avg_valid_i : shunt_raw_valid_i;
	assign bus_sel   = alert_on_average_i ? bus_avg_i : bus_raw_i;
	assign bus_chk   = alert_on_average_i ? bus_avg_valid_i : bus_raw_valid_i;
	assign temp_sel  = alert_on_average_i ? temp_avg_i : temp_raw_i;
	assign temp_chk  = alert_on_average_i ? temp_avg_valid_i : temp_raw_valid_i;
	// scale is shared by threshold and result in either range, so codes compare as-is
	assign power_top = power_i[23:`LTC_POWER_SHIFT];

	assign chk[`LTC_FLAG_SHUNT_OVER]  = shunt_chk;
	assign chk[`LTC_FLAG_SHUNT_UNDER] = shunt_chk;
	assign chk[`LTC_FLAG_BUS_OVER]    = bus_chk;
	assign chk[`LTC_FLAG_BUS_UNDER]   = bus_chk;
	assign chk[`LTC_FLAG_TEMP_OVER]   = temp_chk;
	assign chk[`LTC_FLAG_POWER_OVER]  = power_valid_i;

	// signed compare so a negative over threshold trips at zero
	assign fault[`LTC_FLAG_SHUNT_OVER] =
		$signed(shunt_sel) > $signed(shunt_over_threshold);
	assign fault[`LTC_FLAG_SHUNT_UNDER] =
		$signed(shunt_sel) < $signed(shunt_under_threshold);
	assign fault[`LTC_FLAG_BUS_OVER]  = bus_sel > {1'b0, bus_over_threshold};
	assign fault[`LTC_FLAG_BUS_UNDER] = bus_sel < {1'b0, bus_under_threshold};
	assign fault[`LTC_FLAG_TEMP_OVER] =
		$signed(temp_sel) > $signed(temp_threshold_field);
	assign fault[`LTC_FLAG_POWER_OVER] = power_top > power_over_field;

	genvar gi;
	generate
		for (gi = 0; gi < `LTC_NFLAGS; gi = gi + 1) begin : g_flag
			ltc_flag u_flag (
				.clock_i     (clock_i),
				.rst_n_i     (rst_n_i),
				.check_i     (chk[gi]),
				.fault_i     (fault[gi]),
				.latch_i     (alert_latch_enable_i),
				.diag_read_i (diag_read_i),
				.flag_o      (flags[gi])
			);
		end
	endgenerate

	assign shunt_over_flag_o  = flags[`LTC_FLAG_SHUNT_OVER];
	assign shunt_under_flag_o = flags[`LTC_FLAG_SHUNT_UNDER];
	assign bus_over_flag_o    = flags[`LTC_FLAG_BUS_OVER];
	assign bus_under_flag_o   = flags[`LTC_FLAG_BUS_UNDER];
	assign temp_over_flag_o   = flags[`LTC_FLAG_TEMP_OVER];
	assign power_over_flag_o  = flags[`LTC_FLAG_POWER_OVER];
endmodule // ltc_limit_threshold_comparator

// ===== design/ltc_map.vh
// Purpose: register offsets, reset values and field positions of the limit threshold comparator
// Assumes: register indices are the printed word addresses of the serial register interface
// Notes: thresholds and results share one scale, so codes compare without conversion, except power, which compares against result bits 23-8
// Function
// - shunt over threshold: 16-bit signed read/write, reset 7FFF, compared each shunt result
// - shunt thresholds share the shunt result scale, selected by shunt input range
// - negative shunt over threshold trips at zero volts via signed compare
// - shunt under threshold: 16-bit signed read/write, reset 8000
// - bus thresholds hold unsigned values in bits 14 to 0
// - bus threshold bit 15 reads zero and stores nothing
// - bus over resets to 7FFF, bus under resets to zero
// - temperature threshold is 12-bit signed in bits 15-4, reset 7FF, low nibble zero
// - temperature field compared directly against die temperature result field
// - read-only maker identification register, fixed code, writes ignored
// - decoder maps thresholds to 0C..11 and identification to 3E
// - over-limit flags set when measurement exceeds threshold
// - under-limit flags set when measurement falls below threshold
// - latched flags hold until diagnostic read; transparent flags follow the fault
// - averaged-alert setting picks averaged shunt, bus and temperature results, otherwise raw results; power has only one source
`ifndef LTC_MAP_VH
`define LTC_MAP_VH
`define LTC_ADDR_SHUNT_OVER   8'h0C
`define LTC_ADDR_SHUNT_UNDER  8'h0D
`define LTC_ADDR_BUS_OVER     8'h0E
`define LTC_ADDR_BUS_UNDER    8'h0F
`define LTC_ADDR_TEMP_OVER    8'h10
`define LTC_ADDR_POWER_OVER   8'h11
`define LTC_ADDR_MAKER_ID     8'h3E
`define LTC_RST_SHUNT_OVER    16'h7FFF
`define LTC_RST_SHUNT_UNDER   16'h8000
`define LTC_RST_BUS_OVER      15'h7FFF
`define LTC_RST_BUS_UNDER     15'h0000
`define LTC_RST_TEMP_OVER     12'h7FF
`define LTC_RST_POWER_OVER    16'hFFFF
// arbitrary neutral identification value
`define LTC_MAKER_CODE        16'h4E58
`define LTC_TEMP_LSB          4
`define LTC_POWER_SHIFT       8
`define LTC_FLAG_TEMP_OVER    5
`define LTC_FLAG_SHUNT_OVER   4
`define LTC_FLAG_SHUNT_UNDER  3
`define LTC_FLAG_BUS_OVER     2
`define LTC_FLAG_BUS_UNDER    1
`define LTC_FLAG_POWER_OVER   0
`define LTC_NFLAGS            6
`endif

// ===== verification/ltc_asserts.sv
// Purpose: port assertions for the limit comparator
// Assumes: one clock, sync active-low reset
// Notes: mirrors only the shunt over threshold, to keep the checker small
`timescale 1ns/1ps
`include "ltc_map.vh"
module ltc_asserts (
	input wire logic        clock_i,
	input wire logic        rst_n_i,
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic        reg_hit_o,
	input wire logic        alert_latch_enable_i,
	input wire logic        alert_on_average_i,
	input wire logic        diag_read_i,
	input wire logic        shunt_raw_valid_i,
	input wire logic        shunt_avg_valid_i,
	input wire logic        shunt_over_flag_o,
	input wire logic [7:0]  reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic [15:0] shunt_raw_i,
	input wire logic [15:0] shunt_avg_i
);
	logic [15:0] so_thr;
	wire         sv       = alert_on_average_i ? shunt_avg_valid_i : shunt_raw_valid_i;
	wire  [15:0] sval     = alert_on_average_i ? shunt_avg_i : shunt_raw_i;
	wire         mapped   = (reg_addr_i >= `LTC_ADDR_SHUNT_OVER && reg_addr_i <= `LTC_ADDR_POWER_OVER)
		|| reg_addr_i == `LTC_ADDR_MAKER_ID;
	wire         rd_miss  = reg_rd_i && !mapped;
	wire         so_fault = $signed(sval) > $signed(so_thr);
	wire         diag_clr = alert_latch_enable_i && diag_read_i && !sv;
	always_ff @(posedge clock_i) begin
		if (!rst_n_i)
			so_thr <= `LTC_RST_SHUNT_OVER;
		else if (reg_wr_i && reg_addr_i == `LTC_ADDR_SHUNT_OVER)
			so_thr <= reg_wdata_i;
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_rd(a); reg_rd_i && reg_addr_i == a; endsequence
	a_unmapped_zero: assert property (rd_miss |=> !reg_rdata_o && !reg_hit_o)
		else $error("unmapped read gave data or hit");
	a_mapped_hit: assert property (reg_rd_i && mapped |=> reg_hit_o)
		else $error("mapped read without hit");
	a_bus_top_zero: assert property (s_rd(8'h0E) or s_rd(8'h0F) |=> !reg_rdata_o[15])
		else $error("bus threshold top bit set");
	a_temp_nibble_zero: assert property (s_rd(8'h10) |=> reg_rdata_o[3:0] == 4'h0)
		else $error("temperature low nibble set");
	a_maker_fixed: assert property (s_rd(8'h3E) |=> reg_rdata_o == `LTC_MAKER_CODE)
		else $error("identification word wrong");
	a_read_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without read");
	a_shunt_over_set: assert property (sv && so_fault |=> shunt_over_flag_o)
		else $error("shunt over flag not set");
	a_diag_clear: assert property (diag_clr |=> !shunt_over_flag_o)
		else $error("latched flag not cleared");
	a_idle_stable: assert property (!sv && !diag_read_i |=> $stable(shunt_over_flag_o))
		else $error("flag moved without result");
endmodule // ltc_asserts

// ===== verification/ltc_host.sv
// Purpose: register host model for the comparator's register port
// Assumes: strobes are one-cycle pulses launched on the rising edge
// Notes: read data is taken one edge after the read strobe
`timescale 1ns/1ps
module ltc_host (
	input  wire logic        clock_i,
	input  wire logic [15:0] rdata_i,
	output logic      [7:0]  addr_o = 8'h00,
	output logic             wr_o = 1'b0,
	output logic      [15:0] wdata_o = 16'h0000,
	output logic             rd_o = 1'b0
);
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock_i);
		addr_o  <= a;
		wdata_o <= d;
		wr_o    <= 1'b1;
		@(posedge clock_i);
		wr_o    <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clock_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge clock_i);
		rd_o   <= 1'b0;
		@(posedge clock_i);
		d = rdata_i;
	endtask
endmodule // ltc_host

// ===== verification/test_ltc_limit_threshold_comparator.sv
// Purpose: directed register and flag tests for the limit comparator
// Assumes: inputs change by non-blocking assignment on the rising edge
// Notes: flags packed as temp, shunt over, shunt under, bus over, bus under, power
`timescale 1ns/1ps
`include "ltc_map.vh"
module test_ltc_limit_threshold_comparator;
	logic        clock_i = 0, rst_n_i = 0, diag_read_i = 0;
	logic        alert_latch_enable_i = 0, alert_on_average_i = 0;
	logic [23:0] val = 0;
	logic [3:0]  vr = 0, va = 0;
	logic [15:0] rv;
	int          num_errors = 0, samples_checked = 0;
	wire  [7:0]  reg_addr_i;
	wire  [15:0] reg_wdata_i, reg_rdata_o, shunt_raw_i = val[15:0], shunt_avg_i = val[15:0];
	wire  [15:0] bus_raw_i = val[15:0], bus_avg_i = val[15:0];
	wire  [11:0] temp_raw_i = val[11:0], temp_avg_i = val[11:0];
	wire  [23:0] power_i = val;
	wire         shunt_raw_valid_i = vr[0], bus_raw_valid_i = vr[1], temp_raw_valid_i = vr[2];
	wire         shunt_avg_valid_i = va[0], bus_avg_valid_i = va[1], temp_avg_valid_i = va[2];
	wire         power_valid_i = vr[3], reg_wr_i, reg_rd_i, reg_hit_o;
	wire         temp_over_flag_o, shunt_over_flag_o, shunt_under_flag_o;
	wire         bus_over_flag_o, bus_under_flag_o, power_over_flag_o;
	logic [7:0]  ad [7] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h3E};
	logic [15:0] rs [7] = '{16'h7FFF, 16'h8000, 16'h7FFF, 16'h0000, 16'h7FF0, 16'hFFFF, 16'h4E58};
	logic [15:0] hi [7] = '{16'hFFFF, 16'hFFFF, 16'h7FFF, 16'h7FFF, 16'hFFF0, 16'hFFFF, 16'h4E58};
	always #12.5 clock_i = ~clock_i;
	ltc_host host (.clock_i(clock_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .wr_o(reg_wr_i),
		.wdata_o(reg_wdata_i), .rd_o(reg_rd_i));
	ltc_limit_threshold_comparator dut (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.reg_hit_o(reg_hit_o), .alert_latch_enable_i(alert_latch_enable_i),
		.alert_on_average_i(alert_on_average_i), .diag_read_i(diag_read_i),
		.shunt_raw_i(shunt_raw_i), .shunt_raw_valid_i(shunt_raw_valid_i),
		.shunt_avg_i(shunt_avg_i), .shunt_avg_valid_i(shunt_avg_valid_i),
		.bus_raw_i(bus_raw_i), .bus_raw_valid_i(bus_raw_valid_i),
		.bus_avg_i(bus_avg_i), .bus_avg_valid_i(bus_avg_valid_i),
		.temp_raw_i(temp_raw_i), .temp_raw_valid_i(temp_raw_valid_i),
		.temp_avg_i(temp_avg_i), .temp_avg_valid_i(temp_avg_valid_i),
		.power_i(power_i), .power_valid_i(power_valid_i),
		.shunt_over_flag_o(shunt_over_flag_o), .shunt_under_flag_o(shunt_under_flag_o),
		.bus_over_flag_o(bus_over_flag_o), .bus_under_flag_o(bus_under_flag_o),
		.temp_over_flag_o(temp_over_flag_o), .power_over_flag_o(power_over_flag_o)
	);
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one result on channel ch, then the six flags are compared
	task put(input int ch, input logic [23:0] v, input logic avg, input logic [5:0] exp);
		@(posedge clock_i);
		val <= v;
		if (avg) va <= 4'h1 << ch;
		else vr <= 4'h1 << ch;
		@(posedge clock_i);
		va <= 0;
		vr <= 0;
		@(posedge clock_i);
		chk({10'h000, temp_over_flag_o, shunt_over_flag_o, shunt_under_flag_o,
			bus_over_flag_o, bus_under_flag_o, power_over_flag_o}, {10'h000, exp});
	endtask
	task print_verdict;
		$display("errors %0d, checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		print_verdict();
	end
	initial begin
		repeat (16) @(posedge clock_i);
		rst_n_i <= 1;
		for (int i = 0; i < 7; i++) begin
			host.rd(ad[i], rv);
			chk(rv, rs[i]);
			host.wr(ad[i], 16'hFFFF);
			host.rd(ad[i], rv);
			chk(rv, hi[i]);
		end
		host.rd(8'h20, rv);
		chk(rv | {15'h0000, reg_hit_o}, 16'h0000);
		host.wr(8'h0D, 16'hFFFE);
		put(0, 24'h000000, 0, 6'b010000);
		put(0, 24'h00FFFD, 0, 6'b001000);
		host.wr(8'h0E, 16'h0010);
		host.wr(8'h0F, 16'h8008);
		put(1, 24'h000010, 0, 6'b001000);
		put(1, 24'h000011, 0, 6'b001100);
		put(1, 24'h000007, 0, 6'b001010);
		put(2, 24'h000000, 0, 6'b101010);
		host.wr(8'h10, 16'h0100);
		alert_on_average_i <= 1;
		put(2, 24'h000005, 0, 6'b101010);
		put(2, 24'h000005, 1, 6'b001010);
		host.wr(8'h11, 16'h0100);
		put(3, 24'h010100, 0, 6'b001011);
		put(3, 24'h0100FF, 0, 6'b001010);
		alert_latch_enable_i <= 1;
		put(3, 24'h010100, 0, 6'b001011);
		put(3, 24'h000000, 0, 6'b001011);
		diag_read_i <= 1;
		put(3, 24'h000000, 1, 6'b000000);
		put(3, 24'h010100, 0, 6'b000001);
		diag_read_i <= 0;
		print_verdict();
	end
endmodule // test_ltc_limit_threshold_comparator
bind ltc_limit_threshold_comparator ltc_asserts chk_u (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_hit_o(reg_hit_o), .alert_latch_enable_i(alert_latch_enable_i),
	.alert_on_average_i(alert_on_average_i), .diag_read_i(diag_read_i),
	.shunt_raw_valid_i(shunt_raw_valid_i), .shunt_avg_valid_i(shunt_avg_valid_i),
	.shunt_over_flag_o(shunt_over_flag_o), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .shunt_raw_i(shunt_raw_i),
	.shunt_avg_i(shunt_avg_i)
);
